/* design/mcx_cfg.svh */
// constants for the chip management block
`ifndef MCX_CFG_SVH
`define MCX_CFG_SVH
`define MCX_CLK_MHZ 250
`define MCX_PRST_NS 1000
`define MCX_EE_QTR_NS 2500
`define MCX_PROBE_CYC 4'h8
`define MCX_PRE_ONES 6'h20
`define MCX_A_INT_MODE 9'h003
`define MCX_A_CHIP_MODE 9'h009
`define MCX_A_SONET 9'h00b
`define MCX_R_CTRL 5'h00
`define MCX_R_STAT 5'h01
`define MCX_R_ID1 5'h02
`define MCX_R_ID2 5'h03
`define MCX_R_IND_ADDR 5'h10
`define MCX_R_IND_DATA 5'h11
`define MCX_R_ALARM 5'h12
`define MCX_CTL_RST 15
`define MCX_CTL_LOOP 14
`define MCX_CTL_ISO 10
`define MCX_CTL_FIXED 16'h2100
`define MCX_STAT_FIXED 16'h4001
`define MCX_STAT_LINK 2
`define MCX_MODE_GFP 0
`define MCX_MODE_PHY 1
`define MCX_SONET_SDH 0
`define MCX_OP_RD 2'h2
`define MCX_OP_WR 2'h1
`define MCX_EE_CTRL_RD 8'ha1
`endif

/* design/mcx_pkg.sv */
// types of the chip management block
`default_nettype none
package mcx_pkg;
	typedef enum logic [2:0] {LS_PROBE, LS_START, LS_CTRL, LS_CACK, LS_RBYTE, LS_RACK, LS_STOP,
		LS_RUN} mcx_ld_e;
	typedef enum logic [2:0] {MS_PRE, MS_ST, MS_HDR, MS_TA, MS_DAT} mcx_md_e;
	typedef struct packed {
		mcx_md_e st;
		logic mdc_q;
		logic [5:0] ones;
		logic [3:0] cnt;
		logic [15:0] sh;
		logic rd_op;
		logic [4:0] reg_a;
		logic out;
		logic oe_n;
		logic rd;
		logic wr;
	} mcx_mdio_s;
	typedef struct packed {
		mcx_ld_e ld;
		logic [3:0] probe;
		logic [15:0] qdiv;
		logic [1:0] q;
		logic [2:0] bitn;
		logic [7:0] sh;
		logic [1:0] bsel;
		logic [9:0] left;
		logic nack;
		logic [8:0] ee_addr;
		logic scl_oe_n;
		logic sda_oe_n;
		logic loading;
		logic low;
		logic [8:0] ind_addr;
		logic [1:0] int_mode;
		logic gfp;
		logic phy;
		logic sdh;
		logic loop;
		logic iso;
		logic phy_rst;
		logic [15:0] prst;
		logic busy;
		logic acc_mdio;
		logic acc_rd;
		logic [8:0] acc_addr;
		logic md_pend;
		logic md_pw;
		logic [7:0] md_wd;
		logic cpu_pend;
		logic cpu_pw;
		logic [8:0] cpu_pa;
		logic [7:0] cpu_pd;
		logic [15:0] mrd;
		logic mrd_ok;
		logic [7:0] cpu_rdata;
		logic cpu_rdy;
		logic int_out;
		logic int_oe_n;
		logic clk_oe_n;
		logic rx_oe_n;
		logic tx_take;
	} mcx_top_s;
endpackage : mcx_pkg
`default_nettype wire

/* design/mcx_chip_ram.sv */
// internal chip register storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module mcx_chip_ram #(
	parameter int AW = 9,
	parameter int DW = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic en,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	if (AW < 1 || AW > 16 || DW < 1)
	begin : g_chk
		$error("mcx_chip_ram: unsupported size");
	end

	always_ff @(posedge clk)
	begin
		if (en && we)
			mem[addr] <= wdata;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			rdata <= '0;
		else if (en)
			rdata <= mem[addr];
	end
endmodule : mcx_chip_ram
`default_nettype wire

/* design/mcx_mdio_slave.sv */
// serial management frame engine
`timescale 1ns/1ps
`default_nettype none
`include "mcx_cfg.svh"
module mcx_mdio_slave import mcx_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic en,
	input wire logic mdc,
	input wire logic mdio_in,
	input wire logic [4:0] phy_addr,
	input wire logic [15:0] rd_data,
	input wire logic rd_ok,
	output logic mdio_out,
	output logic mdio_oe_n,
	output logic rd,
	output logic wr,
	output logic [4:0] reg_a,
	output logic [15:0] wr_data
);
	mcx_mdio_s s, n;
	logic [15:0] nsh;

	always_comb
	begin
		n = s;
		n.rd = 1'b0;
		n.wr = 1'b0;
		n.mdc_q = mdc;
		nsh = {s.sh[14:0], mdio_in};
		if (!en)
		begin
			n.st = MS_PRE;
			n.ones = 6'h00;
			n.oe_n = 1'b1;
		end
		else if (mdc && !s.mdc_q)
		begin
			case (s.st)
				MS_PRE:
				begin
					if (mdio_in)
					begin
						if (s.ones != `MCX_PRE_ONES)
							n.ones = s.ones + 6'h01;
					end
					else
					begin
						n.ones = 6'h00;
						if (s.ones == `MCX_PRE_ONES)
							n.st = MS_ST;
					end
				end
				MS_ST:
				begin
					n.ones = 6'h00;
					n.cnt = 4'h0;
					n.st = mdio_in ? MS_HDR : MS_PRE;
				end
				MS_HDR:
				begin
					n.sh = nsh;
					n.cnt = s.cnt + 4'h1;
					if (s.cnt == 4'hb)
					begin
						n.cnt = 4'h0;
						n.reg_a = nsh[4:0];
						n.rd_op = (nsh[11:10] == `MCX_OP_RD);
						n.st = MS_PRE;
						if (nsh[9:5] == phy_addr && (nsh[11:10] == `MCX_OP_RD ||
							nsh[11:10] == `MCX_OP_WR))
						begin
							n.st = MS_TA;
							n.rd = n.rd_op; // (R25)
						end
					end
				end
				MS_TA:
				begin
					n.cnt = s.cnt + 4'h1;
					if (s.cnt == 4'h0)
					begin
						if (s.rd_op && rd_ok)
						begin
							n.sh = rd_data;
							n.out = 1'b0;
							n.oe_n = 1'b0; // (R25)
						end
						else if (s.rd_op)
							n.st = MS_PRE;
					end
					else
					begin
						n.st = MS_DAT;
						n.cnt = 4'h0;
						if (s.rd_op)
						begin
							n.out = s.sh[15];
							n.sh = {s.sh[14:0], 1'b0};
						end
					end
				end
				MS_DAT:
				begin
					n.cnt = s.cnt + 4'h1;
					if (s.rd_op)
					begin
						n.out = s.sh[15];
						n.sh = {s.sh[14:0], 1'b0};
					end
					else
						n.sh = nsh;
					if (s.cnt == 4'hf)
					begin
						n.st = MS_PRE;
						n.oe_n = 1'b1;
						n.wr = !s.rd_op; // (R25)
					end
				end
				default: n.st = MS_PRE;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			s <= '0;
			s.oe_n <= 1'b1;
		end
		else
			s <= n;
	end

	assign mdio_out = s.out;
	assign mdio_oe_n = s.oe_n;
	assign rd = s.rd;
	assign wr = s.wr;
	assign reg_a = s.reg_a;
	assign wr_data = s.sh;
endmodule : mcx_mdio_slave
`default_nettype wire

/* design/mcx_mgmt.sv */
// chip setup, interrupt pin and management register block
//
// Overview of operation
// (R1) sda low after reset: no boot load
// (R2) sda high: load registers from eeprom
// (R3) ignore host and serial ports while loading
// (R4) phy side drives both interface clocks; the code drives them only while isolate (control bit 10) is clear
// (R5) mac side takes both clocks as inputs
// (R6) reset default is mac side
// (R7) host sets side once after reset
// (R8) default sonet, register bit selects sdh
// (R9) default laps, chip mode 0x01 selects gfp
// (R10) host programs gfp null header values
// (R11) host sets rx fifo threshold 0x14
// (R12) style 00 open drain, active low
// (R13) style 01 open source, active high
// (R14) style 10 always driven, active low
// (R15) style 11 always driven, active high
// (R16) serial regs only via serial port
// (R17) reg 16 address, reg 17 write data
// (R18) reg 16 address, read reg 17
// (R19) control bit 15 resets, self clears
// (R20) control bit 14 loopback, reset 0
// (R21) control bit 10 isolate, reset 1
// (R22) fixed speed, duplex and ability bits
// (R23) reg 16 bits 8..0 hold address
// (R24) reg 17 upper byte reads zero
// (R25) clause 22 framing on management clock
`timescale 1ns/1ps
`default_nettype none
`include "mcx_cfg.svh"
module mcx_mgmt import mcx_pkg::*; #(
	parameter int PRST_CYCLES = (`MCX_PRST_NS * `MCX_CLK_MHZ) / 1000,
	parameter int EE_QTR_CYCLES = (`MCX_EE_QTR_NS * `MCX_CLK_MHZ) / 1000,
	parameter logic [15:0] ID1 = 16'h5a5a, // arbitrary value
	parameter logic [15:0] ID2 = 16'ha5a0 // arbitrary value
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe_n,
	input wire logic [4:0] phy_addr,
	output logic ee_scl_out,
	output logic ee_scl_oe_n,
	input wire logic ee_sda_in,
	output logic ee_sda_out,
	output logic ee_sda_oe_n,
	input wire logic cpu_cs,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic [8:0] cpu_addr,
	input wire logic [7:0] cpu_wdata,
	output logic [7:0] cpu_rdata,
	output logic cpu_rdy,
	input wire logic msk_int,
	output logic int_out,
	output logic int_out_buf_enable_n,
	input wire logic sonet_up,
	input wire logic [7:0] master_alarm,
	output logic phy_mode,
	output logic sdh_mode,
	output logic gfp_mode,
	output logic loopback,
	output logic phy_reset,
	output logic mii_clk_oe_n,
	output logic mii_rx_oe_n,
	output logic mii_tx_take,
	output logic loading
);
	localparam logic [15:0] PRST_LOAD = 16'(PRST_CYCLES - 1);
	localparam logic [15:0] QTR_LOAD = 16'(EE_QTR_CYCLES - 1);

	mcx_top_s s, n;
	logic md_rd, md_wr, m_en, m_we, tick;
	logic [4:0] md_reg;
	logic [15:0] md_wd;
	logic [8:0] m_addr;
	logic [7:0] m_wd, m_q, rb;

	if (PRST_CYCLES < 1 || PRST_CYCLES > 65536 || EE_QTR_CYCLES < 1 || EE_QTR_CYCLES > 65536)
	begin : g_chk
		$error("mcx_mgmt: count out of range");
	end

	// ************************************
	// chip register side effects
	// ************************************
	function automatic mcx_top_s cfg_wr(input mcx_top_s t, input logic [8:0] a,
		input logic [7:0] d);
		mcx_top_s r;
		r = t;
		case (a)
			`MCX_A_INT_MODE: r.int_mode = d[1:0];
			`MCX_A_CHIP_MODE:
			begin
				r.gfp = d[`MCX_MODE_GFP]; // (R9)
				r.phy = d[`MCX_MODE_PHY];
			end
			`MCX_A_SONET: r.sdh = d[`MCX_SONET_SDH]; // (R8)
			default: r = t;
		endcase
		return r;
	endfunction : cfg_wr

	function automatic logic [7:0] cfg_rd(input mcx_top_s t, input logic [8:0] a,
		input logic [7:0] q);
		case (a)
			`MCX_A_INT_MODE: cfg_rd = {6'h00, t.int_mode};
			`MCX_A_CHIP_MODE: cfg_rd = {6'h00, t.phy, t.gfp};
			`MCX_A_SONET: cfg_rd = {7'h00, t.sdh};
			default: cfg_rd = q;
		endcase
	endfunction : cfg_rd

	// ************************************
	// next state
	// ************************************
	always_comb
	begin
		n = s;
		n.cpu_rdy = 1'b0;
		m_en = 1'b0;
		m_we = 1'b0;
		m_addr = s.acc_addr;
		m_wd = 8'h00;
		rb = 8'h00;
		tick = (s.qdiv == 16'h0000);
		case (s.int_mode)
			2'h0:
			begin
				n.int_out = 1'b0;
				n.int_oe_n = !msk_int; // (R12)
			end
			2'h1:
			begin
				n.int_out = 1'b1;
				n.int_oe_n = !msk_int; // (R13)
			end
			2'h2:
			begin
				n.int_out = !msk_int;
				n.int_oe_n = 1'b0; // (R14)
			end
			default:
			begin
				n.int_out = msk_int;
				n.int_oe_n = 1'b0; // (R15)
			end
		endcase
		// side is taken as set once after reset
		n.clk_oe_n = !(s.phy && !s.iso); // (R4) (R5) (R7)
		n.rx_oe_n = s.iso; // (R21)
		n.tx_take = !s.iso; // (R21)
		if (s.phy_rst)
		begin
			if (s.prst == 16'h0000)
			begin
				n.phy_rst = 1'b0; // (R19)
				n.loop = 1'b0;
				n.iso = 1'b1;
			end
			else
				n.prst = s.prst - 16'h0001;
		end
		// access completion
		if (s.busy)
		begin
			n.busy = 1'b0;
			rb = cfg_rd(s, s.acc_addr, m_q);
			if (s.acc_mdio && s.acc_rd)
			begin
				n.mrd = {8'h00, rb}; // (R18) (R24)
				n.mrd_ok = 1'b1;
			end
			else if (!s.acc_mdio)
			begin
				n.cpu_rdy = 1'b1;
				if (s.acc_rd)
					n.cpu_rdata = rb;
			end
		end
		// access start, serial port first
		if (!s.loading && !s.busy && (s.md_pend || s.cpu_pend))
		begin
			n.busy = 1'b1;
			m_en = 1'b1;
			n.acc_mdio = s.md_pend;
			if (s.md_pend)
			begin
				n.md_pend = 1'b0;
				n.acc_rd = !s.md_pw;
				m_addr = s.ind_addr; // (R17) (R18)
				m_we = s.md_pw;
				m_wd = s.md_wd;
			end
			else
			begin
				n.cpu_pend = 1'b0;
				n.acc_rd = !s.cpu_pw;
				m_addr = s.cpu_pa;
				m_we = s.cpu_pw;
				m_wd = s.cpu_pd;
			end
			n.acc_addr = m_addr;
		end
		// serial register reads
		if (md_rd)
		begin
			n.mrd_ok = 1'b1;
			case (md_reg)
				`MCX_R_CTRL:
				begin
					n.mrd = `MCX_CTL_FIXED; // (R22)
					n.mrd[`MCX_CTL_RST] = s.phy_rst;
					n.mrd[`MCX_CTL_LOOP] = s.loop;
					n.mrd[`MCX_CTL_ISO] = s.iso;
				end
				`MCX_R_STAT:
				begin
					n.mrd = `MCX_STAT_FIXED; // (R22)
					n.mrd[`MCX_STAT_LINK] = sonet_up;
				end
				`MCX_R_ID1: n.mrd = ID1;
				`MCX_R_ID2: n.mrd = ID2;
				`MCX_R_IND_ADDR: n.mrd = {7'h00, s.ind_addr}; // (R23)
				`MCX_R_IND_DATA:
				begin
					n.mrd_ok = 1'b0;
					n.md_pend = 1'b1; // (R18)
					n.md_pw = 1'b0;
				end
				`MCX_R_ALARM: n.mrd = {8'h00, master_alarm};
				default: n.mrd_ok = 1'b0;
			endcase
		end
		// serial register writes
		if (md_wr)
		begin
			case (md_reg)
				`MCX_R_CTRL:
				begin
					n.loop = md_wd[`MCX_CTL_LOOP]; // (R20)
					n.iso = md_wd[`MCX_CTL_ISO]; // (R21)
					if (md_wd[`MCX_CTL_RST])
					begin
						n.phy_rst = 1'b1; // (R19)
						n.prst = PRST_LOAD;
					end
				end
				`MCX_R_IND_ADDR: n.ind_addr = md_wd[8:0]; // (R23)
				`MCX_R_IND_DATA:
				begin
					n.md_pend = 1'b1; // (R17)
					n.md_pw = 1'b1;
					n.md_wd = md_wd[7:0];
				end
				default: n.md_pend = s.md_pend;
			endcase
		end
		// host port reaches the chip map only, one request at a time
		if (!s.loading && !s.cpu_pend && !(s.busy && !s.acc_mdio) && !s.cpu_rdy && cpu_cs &&
			(cpu_wr || cpu_rd)) // (R3) (R16)
		begin
			n.cpu_pend = 1'b1;
			n.cpu_pw = cpu_wr;
			n.cpu_pa = cpu_addr;
			n.cpu_pd = cpu_wdata;
		end
		// ************************************
		// boot loader
		// ************************************
		case (s.ld)
			LS_PROBE:
			begin
				if (s.probe != 4'h0)
					n.probe = s.probe - 4'h1;
				else if (ee_sda_in)
					n.ld = LS_START; // (R2)
				else
				begin
					n.ld = LS_RUN; // (R1)
					n.loading = 1'b0;
				end
			end
			LS_RUN: n.loading = 1'b0;
			default:
			begin
				n.qdiv = tick ? QTR_LOAD : s.qdiv - 16'h0001;
				if (tick)
				begin
					n.q = s.q + 2'h1;
					case (s.q)
						2'h0:
						begin
							n.scl_oe_n = 1'b0;
							case (s.ld)
								LS_CTRL: n.sda_oe_n = s.sh[7];
								LS_RACK: n.sda_oe_n = s.nack;
								LS_STOP: n.sda_oe_n = 1'b0;
								default: n.sda_oe_n = 1'b1;
							endcase
						end
						2'h1: n.scl_oe_n = 1'b1;
						2'h2:
						begin
							case (s.ld)
								LS_START: n.sda_oe_n = 1'b0;
								LS_STOP: n.sda_oe_n = 1'b1;
								LS_CACK, LS_RBYTE: n.sh = {s.sh[6:0], ee_sda_in};
								default: n.sda_oe_n = s.sda_oe_n;
							endcase
						end
						default:
						begin
							n.scl_oe_n = (s.ld == LS_STOP);
							case (s.ld)
								LS_START:
								begin
									n.ld = LS_CTRL;
									n.sh = `MCX_EE_CTRL_RD;
									n.bitn = 3'h7;
								end
								LS_CTRL:
								begin
									n.sh = {s.sh[6:0], 1'b0};
									n.bitn = s.bitn - 3'h1;
									if (s.bitn == 3'h0)
										n.ld = LS_CACK;
								end
								LS_CACK:
								begin
									n.ld = s.sh[0] ? LS_STOP : LS_RBYTE;
									n.bitn = 3'h7;
									n.bsel = 2'h0;
								end
								LS_RBYTE:
								begin
									n.bitn = s.bitn - 3'h1;
									if (s.bitn == 3'h0)
									begin
										n.ld = LS_RACK;
										if (s.bsel == 2'h0)
										begin
											n.left = 10'({2'b00, s.sh, 1'b0} + {3'b000, s.sh});
											n.nack = (s.sh == 8'h00);
											n.bsel = 2'h1;
										end
										else
										begin
											n.left = s.left - 10'h001;
											n.nack = (s.left == 10'h001);
											n.bsel = (s.bsel == 2'h3) ? 2'h1 : s.bsel + 2'h1;
											if (s.bsel == 2'h1)
												n.ee_addr[8] = s.sh[0];
											else if (s.bsel == 2'h2)
												n.ee_addr[7:0] = s.sh;
											else
											begin
												m_en = 1'b1; // (R2)
												m_we = 1'b1;
												m_addr = s.ee_addr;
												m_wd = s.sh;
											end
										end
									end
								end
								LS_RACK:
								begin
									n.ld = s.nack ? LS_STOP : LS_RBYTE;
									n.bitn = 3'h7;
								end
								LS_STOP:
								begin
									n.ld = LS_RUN;
									n.loading = 1'b0;
								end
								default: n.ld = LS_RUN;
							endcase
						end
					endcase
				end
			end
		endcase
		if (m_we)
			n = cfg_wr(n, m_addr, m_wd);
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			s <= '0;
			s.probe <= `MCX_PROBE_CYC;
			s.loading <= 1'b1; // (R3)
			s.scl_oe_n <= 1'b1;
			s.sda_oe_n <= 1'b1;
			s.iso <= 1'b1; // (R21)
			s.int_oe_n <= 1'b1;
			s.clk_oe_n <= 1'b1; // (R6)
			s.rx_oe_n <= 1'b1;
		end
		else
			s <= n;
	end

	// ************************************
	// sub blocks
	// ************************************
	mcx_mdio_slave u_mdio (
		.clk(clk),
		.reset(reset),
		.en(!s.loading), // (R3)
		.mdc(mdc),
		.mdio_in(mdio_in),
		.phy_addr(phy_addr),
		.rd_data(s.mrd),
		.rd_ok(s.mrd_ok),
		.mdio_out(mdio_out),
		.mdio_oe_n(mdio_oe_n),
		.rd(md_rd),
		.wr(md_wr),
		.reg_a(md_reg),
		.wr_data(md_wd)
	);

	mcx_chip_ram #(.AW(9), .DW(8)) u_ram (
		.clk(clk),
		.reset(reset),
		.en(m_en),
		.we(m_we),
		.addr(m_addr),
		.wdata(m_wd),
		.rdata(m_q)
	);

	assign ee_scl_out = s.low;
	assign ee_scl_oe_n = s.scl_oe_n;
	assign ee_sda_out = s.low;
	assign ee_sda_oe_n = s.sda_oe_n;
	assign cpu_rdata = s.cpu_rdata;
	assign cpu_rdy = s.cpu_rdy;
	assign int_out = s.int_out;
	assign int_out_buf_enable_n = s.int_oe_n;
	assign phy_mode = s.phy;
	assign sdh_mode = s.sdh;
	assign gfp_mode = s.gfp;
	assign loopback = s.loop;
	assign phy_reset = s.phy_rst;
	assign mii_clk_oe_n = s.clk_oe_n;
	assign mii_rx_oe_n = s.rx_oe_n;
	assign mii_tx_take = s.tx_take;
	assign loading = s.loading;
endmodule : mcx_mgmt
`default_nettype wire

/* bench/mcx_mgmt_asserts.sv */
// checker for the chip management block
`timescale 1ns/1ps
`default_nettype none
module mcx_mgmt_asserts #(
	parameter int PRST_CYCLES = 4
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic cpu_cs,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic cpu_rdy,
	input wire logic loading,
	input wire logic mdio_oe_n,
	input wire logic msk_int,
	input wire logic int_out_buf_enable_n,
	input wire logic phy_mode,
	input wire logic mii_clk_oe_n,
	input wire logic mii_rx_oe_n,
	input wire logic mii_tx_take,
	input wire logic phy_reset,
	input wire logic loopback,
	input wire logic ee_sda_in
);
	// ********************
	// helper counters
	// ********************
	logic [15:0] hi_cnt;
	logic [4:0] rcnt;
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			hi_cnt <= 16'h0000;
			rcnt <= 5'h00;
		end
		else
		begin
			hi_cnt <= phy_reset ? hi_cnt + 16'h0001 : 16'h0000;
			rcnt <= (rcnt == 5'h1f) ? rcnt : rcnt + 5'h01;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// ********************
	// assertions
	// ********************
	a_rdy_one_cycle: assert property (cpu_rdy |=> !cpu_rdy)
		else $error("ready longer than one cycle");
	a_rdy_answer_time: assert property ($rose(cpu_cs) && (cpu_rd || cpu_wr) && !loading
		|-> ##[3:4] cpu_rdy) else $error("host request not answered in time");
	a_load_ports_quiet: assert property (loading |-> !cpu_rdy && mdio_oe_n)
		else $error("port answered while loading");
	a_no_eeprom_run: assert property (rcnt == 5'h0c && !ee_sda_in |-> !loading)
		else $error("no eeprom but still loading");
	a_eeprom_load_start: assert property (rcnt == 5'h0c && ee_sda_in |-> loading)
		else $error("eeprom present but load not started");
	a_int_float_idle: assert property (int_out_buf_enable_n && !$past(reset)
		|-> !$past(msk_int)) else $error("int pin floats while interrupt active");
	a_iso_pair: assert property (mii_rx_oe_n != mii_tx_take)
		else $error("isolate outputs disagree");
	a_clk_drive_cond: assert property (!mii_clk_oe_n |-> phy_mode && !mii_rx_oe_n)
		else $error("interface clocks driven outside phy side");
	a_prst_length: assert property ($fell(phy_reset) |-> hi_cnt == PRST_CYCLES)
		else $error("phy reset length wrong");
	a_prst_defaults: assert property ($fell(phy_reset)
		|-> ##[0:2] (mii_rx_oe_n && !loopback)) else $error("phy reset left wrong state");
	c_rdy: cover property (cpu_rdy);
	c_prst: cover property ($fell(phy_reset));
	c_clk: cover property (!mii_clk_oe_n);
endmodule : mcx_mgmt_asserts
bind mcx_mgmt mcx_mgmt_asserts #(.PRST_CYCLES(PRST_CYCLES)) chk_u (.clk, .reset, .cpu_cs,
	.cpu_wr, .cpu_rd, .cpu_rdy, .loading, .mdio_oe_n, .msk_int, .int_out_buf_enable_n,
	.phy_mode, .mii_clk_oe_n, .mii_rx_oe_n, .mii_tx_take, .phy_reset, .loopback, .ee_sda_in);
`default_nettype wire

/* bench/mcx_sta_model.sv */
// serial management station model
`timescale 1ns/1ps
`default_nettype none
`include "mcx_cfg.svh"
module mcx_sta_model (
	input wire logic clk,
	input wire logic mdio_out,
	input wire logic mdio_oe_n,
	output logic mdc,
	output logic mdio_in
);
	logic m_oe;
	logic m_bit;
	logic drove;
	// line with pull-up, device wins when driving
	assign mdio_in = !mdio_oe_n ? mdio_out : (m_oe ? m_bit : 1'b1);
	initial
	begin
		mdc = 1'b0;
		m_oe = 1'b0;
		m_bit = 1'b1;
		drove = 1'b0;
	end
	always @(posedge clk)
	begin
		if (mdio_oe_n === 1'b0)
			drove <= 1'b1;
	end
	// one mdc period, 16 clk, sample just before the rise
	task slot(input logic oe, input logic b, output logic s);
		@(negedge clk);
		mdc = 1'b0;
		m_oe = oe;
		m_bit = b;
		repeat (7) @(negedge clk);
		s = mdio_in;
		mdc = 1'b1;
		repeat (8) @(negedge clk);
	endtask : slot
	// full frame: preamble, start, op, addresses, turnaround, data
	task frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd, output logic [17:0] rv, output logic dv);
		logic [45:0] hdr;
		logic [17:0] w18;
		logic s;
		int i;
		hdr = {32'hffff_ffff, 2'h1, op, pa, ra};
		w18 = {2'h2, wd};
		drove = 1'b0;
		for (i = 45; i >= 0; i--)
			slot(1'b1, hdr[i], s);
		for (i = 17; i >= 0; i--)
		begin
			slot(op == `MCX_OP_WR, w18[i], s);
			rv[i] = s;
		end
		slot(1'b0, 1'b1, s);
		@(negedge clk);
		mdc = 1'b0;
		dv = drove;
	endtask : frame
endmodule : mcx_sta_model
`default_nettype wire

/* bench/tb.sv */
// testbench for the chip management block
`timescale 1ns/1ps
`default_nettype none
`include "mcx_cfg.svh"
module tb;
	logic clk = 1'b0;
	logic reset, mdc, mdio_in, mdio_out, mdio_oe_n, scl_out, scl_oe_n, sda_out, sda_oe_n;
	logic cpu_cs, cpu_wr, cpu_rd, cpu_rdy, msk_int, int_out, int_oe_n, sonet_up, pull;
	logic phy_mode, sdh_mode, gfp_mode, loopback, phy_reset, clk_oe_n, rx_oe_n, tx_take, loading;
	logic [8:0] cpu_addr;
	logic [7:0] cpu_wdata, cpu_rdata;
	int n_errors = 0;
	int check_count = 0;
	wire logic ee_sda = sda_oe_n ? pull : 1'b0;
	always #2 clk = ~clk;
	mcx_mgmt #(.PRST_CYCLES(4), .EE_QTR_CYCLES(4)) dut_u (.clk(clk), .reset(reset), .mdc(mdc),
		.mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .phy_addr(5'h05),
		.ee_scl_out(scl_out), .ee_scl_oe_n(scl_oe_n), .ee_sda_in(ee_sda),
		.ee_sda_out(sda_out), .ee_sda_oe_n(sda_oe_n), .cpu_cs(cpu_cs), .cpu_wr(cpu_wr),
		.cpu_rd(cpu_rd), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
		.cpu_rdy(cpu_rdy), .msk_int(msk_int), .int_out(int_out),
		.int_out_buf_enable_n(int_oe_n), .sonet_up(sonet_up), .master_alarm(8'h5c),
		.phy_mode(phy_mode), .sdh_mode(sdh_mode), .gfp_mode(gfp_mode), .loopback(loopback),
		.phy_reset(phy_reset), .mii_clk_oe_n(clk_oe_n), .mii_rx_oe_n(rx_oe_n),
		.mii_tx_take(tx_take), .loading(loading));
	mcx_sta_model sta_u (.clk(clk), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .mdc(mdc),
		.mdio_in(mdio_in));
	// ********************
	// shared tasks
	// ********************
	task wrap_up;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	task cmp(input logic [18:0] got, input logic [18:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task cpu(input logic w, input logic [8:0] a, input logic [7:0] d, input int lim,
		output logic ok, output logic [7:0] q);
		int i;
		ok = 1'b0;
		q = 8'h00;
		@(negedge clk);
		{cpu_cs, cpu_wr, cpu_rd, cpu_addr, cpu_wdata} = {1'b1, w, !w, a, d};
		for (i = 0; i < lim && !ok; i++)
		begin
			@(negedge clk);
			if (cpu_rdy === 1'b1)
				{ok, q} = {1'b1, cpu_rdata};
		end
		@(negedge clk);
		{cpu_cs, cpu_wr, cpu_rd} = 3'h0;
	endtask : cpu
	task cw(input logic [8:0] a, input logic [7:0] d);
		logic ok;
		logic [7:0] q;
		cpu(1'b1, a, d, 20, ok, q);
		cmp(ok, 1'b1);
	endtask : cw
	task cr(input logic [8:0] a, input logic [7:0] e);
		logic ok;
		logic [7:0] q;
		cpu(1'b0, a, 8'h00, 20, ok, q);
		cmp({ok, q}, {1'b1, e});
	endtask : cr
	task mw(input logic [4:0] ra, input logic [15:0] d);
		logic [17:0] rv;
		logic dv;
		sta_u.frame(`MCX_OP_WR, 5'h05, ra, d, rv, dv);
		cmp(dv, 1'b0);
	endtask : mw
	task mr(input logic [4:0] pa, input logic [4:0] ra, input logic [17:0] e, input logic de);
		logic [17:0] rv;
		logic dv;
		sta_u.frame(`MCX_OP_RD, pa, ra, 16'h0000, rv, dv);
		cmp({dv, de ? rv : 18'h0_0000}, {de, e});
	endtask : mr
	task do_reset(input logic p);
		int i;
		{reset, pull} = {1'b1, p};
		repeat (10) @(negedge clk);
		reset = 1'b0;
		for (i = 0; i < 6000 && loading !== 1'b0; i++)
			@(negedge clk);
		cmp(loading, 1'b0);
	endtask : do_reset
	// ********************
	// scenarios
	// ********************
	task t_defaults;
		cmp({phy_mode, sdh_mode, gfp_mode, loopback, clk_oe_n, rx_oe_n, tx_take}, 7'h06);
		mr(5'h05, 5'h00, 18'h2_2500, 1'b1);
		mr(5'h05, 5'h01, 18'h2_4005, 1'b1);
		mr(5'h05, 5'h10, 18'h2_0000, 1'b1);
		mr(5'h05, 5'h12, 18'h2_005c, 1'b1);
		mr(5'h05, 5'h04, 18'h0_0000, 1'b0);
		mr(5'h06, 5'h01, 18'h0_0000, 1'b0);
	endtask : t_defaults
	task t_int_modes;
		logic [1:0] e;
		int m, k;
		for (m = 0; m < 4; m++)
		begin
			cw(9'h003, 8'(m));
			cr(9'h003, 8'(m));
			for (k = 0; k < 2; k++)
			begin
				msk_int = k[0];
				repeat (3) @(negedge clk);
				e = (m < 2) ? {!k[0], m[0]} : {1'b0, k[0] ~^ m[0]};
				cmp({int_oe_n, int_out}, e);
			end
		end
		msk_int = 1'b0;
	endtask : t_int_modes
	task t_modes;
		cw(9'h00b, 8'h01);
		cmp({gfp_mode, sdh_mode, phy_mode, clk_oe_n}, 4'hd);
		mw(5'h00, 16'h4000);
		cmp({clk_oe_n, rx_oe_n, tx_take, loopback}, 4'hb);
		mr(5'h05, 5'h00, 18'h2_6100, 1'b1);
	endtask : t_modes
	task t_indirect;
		logic [8:0] ad[7] = '{9'h009, 9'h182, 9'h183, 9'h187, 9'h1ca, 9'h1cb, 9'h1ce};
		logic [7:0] dt[7] = '{8'h01, 8'h01, 8'h10, 8'h04, 8'h01, 8'h10, 8'ha0};
		int i;
		for (i = 0; i < 7; i++)
		begin
			mw(5'h10, {7'h00, ad[i]});
			mw(5'h11, {8'hff, dt[i]});
			cr(ad[i], dt[i]);
		end
		cw(9'h1c2, 8'h14);
		for (i = 0; i < 7; i++)
		begin
			mw(5'h10, {7'h00, ad[i]});
			mr(5'h05, 5'h11, {2'h2, 8'h00, dt[i]}, 1'b1);
		end
		cmp({gfp_mode, phy_mode}, 2'h2);
	endtask : t_indirect
	task t_phy_reset;
		mw(5'h00, 16'h8000);
		cmp({phy_reset, loopback, rx_oe_n}, 3'h1);
		mr(5'h05, 5'h00, 18'h2_2500, 1'b1);
	endtask : t_phy_reset
	task t_boot;
		logic ok;
		logic [7:0] q;
		{reset, pull} = 2'h3;
		repeat (10) @(negedge clk);
		reset = 1'b0;
		repeat (30) @(negedge clk);
		cmp({scl_out, sda_out, loading}, 3'h1);
		cpu(1'b0, 9'h009, 8'h00, 20, ok, q);
		cmp(ok, 1'b0);
		do_reset(1'b1);
		cr(9'h009, 8'h00);
		cw(9'h009, 8'h02);
		cmp({phy_mode, clk_oe_n}, 2'h3);
		mw(5'h00, 16'h0000);
		cmp({phy_mode, clk_oe_n, rx_oe_n}, 3'h4);
	endtask : t_boot
	// ********************
	// main sequence
	// ********************
	initial
	begin
		{reset, pull, cpu_cs, cpu_wr, cpu_rd, msk_int, sonet_up} = 7'h41;
		{cpu_addr, cpu_wdata} = 17'h0_0000;
		do_reset(1'b0);
		t_defaults();
		t_int_modes();
		t_indirect();
		t_modes();
		t_phy_reset();
		t_boot();
		wrap_up();
	end
	initial
	begin
		repeat (90000) @(posedge clk);
		n_errors++;
		$display("[ERR] %0t run did not finish", $time);
		wrap_up();
	end
endmodule : tb
`default_nettype wire
